// ===== core/nvhc_defines.svh
`ifndef NVHC_DEFINES_SVH
`define NVHC_DEFINES_SVH

// clock period in ns
`define NVHC_CLK_NS        50
// write pulse / chip-select low time, ns (slowest grade)
`define NVHC_PULSE_NS      30
// read access time, ns (slowest grade)
`define NVHC_ACCESS_NS     45
// soft sequence processing time, us
`define NVHC_TSS_US        100
// software recall duration, us
`define NVHC_TRECALL_US    200
// store duration, ms
`define NVHC_TSTORE_MS     8
// power-up recall duration, ms
`define NVHC_TPOWERUP_MS   20
// hardware store pulse, ns
`define NVHC_PHSB_NS       15
`define NVHC_SEQ_LEN       6
`define NVHC_ZERO16        16'h0000
`define NVHC_ONE16         16'h0001

`endif

// ===== core/nvhc_pkg.sv
package nvhc_pkg;
  typedef enum logic [1:0] {
    NVHC_OP_READ,
    NVHC_OP_WRITE,
    NVHC_OP_STORE,
    NVHC_OP_RECALL
  } nvhc_op_e;

  typedef enum logic [2:0] {
    NVHC_IDLE,
    NVHC_SETUP,
    NVHC_STROBE,
    NVHC_HOLD,
    NVHC_HWSTORE,
    NVHC_WAIT,
    NVHC_POWERUP
  } nvhc_state_e;
endpackage

// ===== core/nvhc_host.sv
// Function
// - the host holds the write strobe high for the whole of every read.
// - the host keeps store-busy high during every ordinary read and write.
// - clock register writes are timed by chip select or write strobe only.
// - lower lane enable is low before chip select or write strobe falls.
// - software commands are select or output-drive timed reads.
// - a software command is six ordered reads with the strobe high.
`timescale 1ns/1ps
`include "nvhc_defines.svh"

module nvhc_host
  import nvhc_pkg::*;
#(
  parameter int ADDR_W      = 18,
  parameter int DATA_W      = 16,
  parameter int STORE_CYC   = `NVHC_TSTORE_MS * 1000000 / `NVHC_CLK_NS,
  parameter int POWERUP_CYC = `NVHC_TPOWERUP_MS * 1000000 / `NVHC_CLK_NS,
  parameter int RECALL_CYC  = `NVHC_TRECALL_US * 1000 / `NVHC_CLK_NS,
  parameter int TSS_CYC     = `NVHC_TSS_US * 1000 / `NVHC_CLK_NS,
  parameter logic [ADDR_W-1:0] SEQ_A0 = 'h0,
  parameter logic [ADDR_W-1:0] SEQ_A1 = 'h1,
  parameter logic [ADDR_W-1:0] SEQ_A2 = 'h2,
  parameter logic [ADDR_W-1:0] SEQ_A3 = 'h3,
  parameter logic [ADDR_W-1:0] SEQ_A4 = 'h4,
  parameter logic [ADDR_W-1:0] SEQ_ST = 'h5,
  parameter logic [ADDR_W-1:0] SEQ_RC = 'h6
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              req_valid,
  input  wire nvhc_op_e          req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lanes,
  input  wire logic              req_hw_store,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   chip_sel_n,
  output logic                   write_strobe_n,
  output logic                   out_drive_n,
  output logic                   upper_byte_lane_n,
  output logic                   lower_byte_lane_n,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic                   store_busy_n_out,
  output logic                   store_busy_n_oe,
  input  wire logic              store_busy_n_in
);

  localparam int PULSE_CYC_RAW = (`NVHC_ACCESS_NS + `NVHC_CLK_NS - 1)
                                 / `NVHC_CLK_NS;
  localparam int PULSE_CYC = PULSE_CYC_RAW < 1 ? 1 : PULSE_CYC_RAW;
  localparam int PHSB_CYC_RAW = (`NVHC_PHSB_NS + `NVHC_CLK_NS - 1)
                                / `NVHC_CLK_NS;
  localparam int PHSB_CYC = PHSB_CYC_RAW < 1 ? 1 : PHSB_CYC_RAW;
  // wide enough for the longest wait plus the command processing time
  localparam int CNT_W = $clog2(POWERUP_CYC + TSS_CYC + STORE_CYC +
                                RECALL_CYC + 2);

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                 input logic       rcl);
    if (idx == 3'h0) begin
      seq_addr = SEQ_A0;
    end else if (idx == 3'h1) begin
      seq_addr = SEQ_A1;
    end else if (idx == 3'h2) begin
      seq_addr = SEQ_A2;
    end else if (idx == 3'h3) begin
      seq_addr = SEQ_A3;
    end else if (idx == 3'h4) begin
      seq_addr = SEQ_A4;
    end else begin
      seq_addr = rcl ? SEQ_RC : SEQ_ST;
    end
  endfunction

  nvhc_state_e       state_reg;
  nvhc_op_e          op_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [2:0]        seq_reg;
  logic              wrote_reg;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= NVHC_POWERUP;
      op_reg    <= NVHC_OP_READ;
      cnt_reg   <= CNT_W'(POWERUP_CYC);
      seq_reg   <= 3'h0;
    end else begin
      case (state_reg)
        NVHC_POWERUP: begin
          if (cnt_reg == '0) begin
            state_reg <= NVHC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        NVHC_IDLE: begin
          seq_reg <= 3'h0;
          if (req_hw_store) begin
            state_reg <= NVHC_HWSTORE;
            cnt_reg   <= CNT_W'(PHSB_CYC);
          end else if (req_valid) begin
            op_reg    <= req_op;
            state_reg <= NVHC_SETUP;
          end
        end
        NVHC_SETUP: begin
          state_reg <= NVHC_STROBE;
          cnt_reg   <= CNT_W'(PULSE_CYC);
        end
        NVHC_STROBE: begin
          if (cnt_reg == '0) begin
            state_reg <= NVHC_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        NVHC_HOLD: begin
          if (op_reg == NVHC_OP_STORE || op_reg == NVHC_OP_RECALL) begin
            if (seq_reg == 3'(`NVHC_SEQ_LEN - 1)) begin
              state_reg <= NVHC_WAIT;
              cnt_reg   <= (op_reg == NVHC_OP_RECALL) ?
                           CNT_W'(TSS_CYC + RECALL_CYC) :
                           (wrote_reg ? CNT_W'(TSS_CYC + STORE_CYC) :
                                        CNT_W'(TSS_CYC));
            end else begin
              seq_reg   <= seq_reg + 1'b1;
              state_reg <= NVHC_SETUP;
            end
          end else begin
            state_reg <= NVHC_IDLE;
          end
        end
        NVHC_HWSTORE: begin
          if (cnt_reg == '0) begin
            state_reg <= NVHC_WAIT;
            cnt_reg   <= wrote_reg ? CNT_W'(STORE_CYC) : CNT_W'(1);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        NVHC_WAIT: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (store_busy_n_in) begin
            state_reg <= NVHC_IDLE;
          end
        end
        default: begin
          state_reg <= NVHC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrote_reg <= 1'b0;
    end else if (state_reg == NVHC_HOLD && op_reg == NVHC_OP_WRITE) begin
      wrote_reg <= 1'b1;
    end else if (state_reg == NVHC_WAIT && cnt_reg == '0 &&
                 store_busy_n_in) begin
      wrote_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_addr          <= '0;
      chip_sel_n        <= 1'b1;
      write_strobe_n    <= 1'b1;
      out_drive_n       <= 1'b1;
      upper_byte_lane_n <= 1'b1;
      lower_byte_lane_n <= 1'b1;
      dq_out            <= '0;
      dq_oe             <= 1'b0;
    end else begin
      chip_sel_n     <= 1'b1;
      write_strobe_n <= 1'b1;
      out_drive_n    <= 1'b1;
      dq_oe          <= 1'b0;
      if (state_reg == NVHC_IDLE && req_valid && !req_hw_store) begin
        // lanes and address settle before any strobe falls
        mem_addr <= (req_op == NVHC_OP_STORE || req_op == NVHC_OP_RECALL) ?
                    seq_addr(3'h0, req_op == NVHC_OP_RECALL) : req_addr;
        upper_byte_lane_n <= (req_op == NVHC_OP_READ ||
                              req_op == NVHC_OP_WRITE) ? ~req_lanes[1] : 1'b0;
        lower_byte_lane_n <= (req_op == NVHC_OP_READ ||
                              req_op == NVHC_OP_WRITE) ? ~req_lanes[0]
                             : 1'b0;
        dq_out <= req_wdata;
      end else if (state_reg == NVHC_HOLD &&
                   (op_reg == NVHC_OP_STORE ||
                    op_reg == NVHC_OP_RECALL)) begin
        mem_addr <= seq_addr(seq_reg + 3'h1, op_reg == NVHC_OP_RECALL);
      end else if (state_reg == NVHC_STROBE) begin
        // chip select times every access, write strobe stays high on reads
        chip_sel_n <= 1'b0;
        if (op_reg == NVHC_OP_WRITE) begin
          write_strobe_n <= 1'b0;
          dq_oe          <= 1'b1;
        end else begin
          out_drive_n <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      store_busy_n_out <= 1'b1;
      store_busy_n_oe  <= 1'b0;
    end else begin
      store_busy_n_out <= 1'b0;
      store_busy_n_oe  <= (state_reg == NVHC_HWSTORE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request and response

  always_ff @(posedge clk) begin
    if (reset) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      req_ready <= (state_reg == NVHC_WAIT && cnt_reg == '0 &&
                    store_busy_n_in) ||
                   (state_reg == NVHC_POWERUP && cnt_reg == '0) ||
                   (state_reg == NVHC_HOLD && op_reg != NVHC_OP_STORE &&
                    op_reg != NVHC_OP_RECALL) ||
                   (req_ready && !req_valid && !req_hw_store);
      rsp_valid <= 1'b0;
      if (state_reg == NVHC_STROBE && cnt_reg == '0 &&
          op_reg == NVHC_OP_READ) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= dq_in;
      end else if (state_reg == NVHC_HOLD && op_reg != NVHC_OP_READ &&
                   (op_reg == NVHC_OP_WRITE ||
                    seq_reg == 3'(`NVHC_SEQ_LEN - 1))) begin
        rsp_valid <= 1'b1;
      end
    end
  end

endmodule

// ===== testbench/nvhc_host_props.sv
`timescale 1ns/1ps
module nvhc_host_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [17:0] mem_addr,
  input wire logic        chip_sel_n,
  input wire logic        write_strobe_n,
  input wire logic        out_drive_n,
  input wire logic        upper_byte_lane_n,
  input wire logic        lower_byte_lane_n,
  input wire logic        dq_oe,
  input wire logic        store_busy_n_out,
  input wire logic        store_busy_n_oe,
  input wire logic        store_busy_n_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RD_WE_HIGH: assert property (
    !chip_sel_n && !out_drive_n |-> write_strobe_n)
    else $error("read with strobe");
  AST_HSB_IDLE: assert property (
    !chip_sel_n |-> !store_busy_n_oe) else $error("store line low in access");
  AST_HSB_DRIVE: assert property (
    store_busy_n_oe |-> !store_busy_n_out)
    else $error("store line driven high");
  AST_LANE_SETUP: assert property (
    $fell(chip_sel_n) |-> $stable(mem_addr) && $stable(lower_byte_lane_n)
      && $stable(upper_byte_lane_n)) else $error("lanes moved at select");
  AST_LOWER_FIRST: assert property (
    $fell(write_strobe_n) && !lower_byte_lane_n
      |-> $stable(lower_byte_lane_n))
    else $error("lower lane late");
  AST_ADDR_HOLD: assert property (
    !chip_sel_n && !$past(chip_sel_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  AST_NO_FIGHT: assert property (
    dq_oe |-> out_drive_n) else $error("host drives during read");
  AST_RSP_PULSE: assert property (
    rsp_valid |=> !rsp_valid) else $error("response too long");
  AST_READY_IDLE: assert property (
    req_ready |-> chip_sel_n && write_strobe_n && !store_busy_n_oe)
    else $error("ready while busy");
  AST_BUSY_BLOCK: assert property (
    !store_busy_n_in |-> !req_ready) else $error("ready during store");
  AST_RESET_QUIET: assert property (
    $past(reset) |-> chip_sel_n && !req_ready && !dq_oe)
    else $error("active after reset");
endmodule
bind nvhc_host nvhc_host_props u_props (.clk, .reset, .req_ready, .rsp_valid,
  .mem_addr, .chip_sel_n, .write_strobe_n, .out_drive_n, .upper_byte_lane_n,
  .lower_byte_lane_n, .dq_oe, .store_busy_n_out, .store_busy_n_oe,
  .store_busy_n_in);

// ===== testbench/nvhc_dev_model.sv
`timescale 1ns/1ps
module nvhc_dev_model #(
  parameter int LK = 10
) (
  input wire logic        clk,
  input wire logic [17:0] mem_addr,
  input wire logic        chip_sel_n,
  input wire logic        write_strobe_n,
  input wire logic        out_drive_n,
  input wire logic        upper_byte_lane_n,
  input wire logic        lower_byte_lane_n,
  input wire logic [15:0] dq_out,
  input wire logic        store_busy_n_oe,
  output logic [15:0]     dq_in,
  output logic            store_busy_n_in
);
  logic [15:0] mem [0:255] = '{default: 16'h0000};
  logic [15:0] nv  [0:255] = '{default: 16'h0000};
  logic [17:0] hist [$];
  logic [15:0] word;
  logic        cs_d  = 1'b1;
  logic        quiet = 1'b0;
  logic        dirty = 1'b0;
  logic        busy  = 1'b0;
  int          lock  = LK; // power-up recall
  int          cmds  = 0;
  int          stores = 0;
  assign word = mem[mem_addr[7:0]];
  // pull-up on the store line; device drives it low while storing
  assign store_busy_n_in = !(store_busy_n_oe || (busy && lock > 0));
  always_comb begin
    dq_in = ~word; // floating lanes show the inverse
    if (!chip_sel_n && write_strobe_n && !out_drive_n && !quiet
        && lock == 0) begin
      if (!lower_byte_lane_n) dq_in[7:0] = word[7:0];
      if (!upper_byte_lane_n) dq_in[15:8] = word[15:8];
    end
  end
  always @(negedge clk) begin
    cs_d <= chip_sel_n;
    if (cs_d && !chip_sel_n) quiet <= !write_strobe_n;
    if (lock > 0) lock <= lock - 1;
    else if (store_busy_n_oe) begin // access in flight already done
      if (dirty) begin // skipped when clean
        nv <= mem;
        busy <= 1'b1;
        lock <= LK;
        dirty <= 1'b0;
        stores <= stores + 1;
      end
    end else if (!chip_sel_n && !write_strobe_n) begin
      if (!lower_byte_lane_n)
        mem[mem_addr[7:0]][7:0] <= dq_out[7:0];
      if (!upper_byte_lane_n)
        mem[mem_addr[7:0]][15:8] <= dq_out[15:8];
      dirty <= 1'b1;
    end else if (cs_d && !chip_sel_n && !out_drive_n) begin
      hist.push_back(mem_addr);
      if (hist.size() > 6) hist.pop_front();
      if (hist.size() == 6 && {hist[0], hist[1], hist[2], hist[3], hist[4]}
          == {18'h0, 18'h1, 18'h2, 18'h3, 18'h4}) begin
        cmds <= cmds + 1;
        lock <= LK;
        busy <= (hist[5] == 18'h5) && dirty;
        dirty <= 1'b0;
        if (hist[5] == 18'h6) mem <= nv;
        else if (dirty) nv <= mem;
        if (hist[5] == 18'h5 && dirty) stores <= stores + 1;
      end
    end
  end
endmodule

// ===== testbench/test_nvhc_host.sv
`timescale 1ns/1ps
module test_nvhc_host;
  import nvhc_pkg::*;
  localparam int LK = 10;
  logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_hw_store = 1'b0;
  nvhc_op_e    req_op = NVHC_OP_READ;
  logic [17:0] req_addr = 18'h00000;
  logic [15:0] req_wdata = 16'h0000, got = 16'h0000;
  logic [1:0]  req_lanes = 2'b11;
  logic req_ready, rsp_valid, cs_n, we_n, oe_n, ub_n, lb_n, dq_oe, sb_oe, sb_in;
  logic [15:0] rsp_rdata, dq_out, dq_in;
  logic [17:0] mem_addr;
  logic        sb_out;
  int          bad_count = 0, samples_checked = 0;
  nvhc_host #(.STORE_CYC(LK), .POWERUP_CYC(LK), .RECALL_CYC(LK),
    .TSS_CYC(LK)) dut (.clk, .reset, .req_valid, .req_op, .req_addr,
    .req_wdata, .req_lanes, .req_hw_store, .req_ready, .rsp_valid, .rsp_rdata,
    .mem_addr, .chip_sel_n(cs_n), .write_strobe_n(we_n), .out_drive_n(oe_n),
    .upper_byte_lane_n(ub_n), .lower_byte_lane_n(lb_n), .dq_out, .dq_oe,
    .dq_in, .store_busy_n_out(sb_out), .store_busy_n_oe(sb_oe),
    .store_busy_n_in(sb_in));
  nvhc_dev_model #(.LK(LK)) dev (.clk, .mem_addr, .chip_sel_n(cs_n),
    .write_strobe_n(we_n), .out_drive_n(oe_n), .upper_byte_lane_n(ub_n),
    .lower_byte_lane_n(lb_n), .dq_out, .store_busy_n_oe(sb_oe), .dq_in,
    .store_busy_n_in(sb_in));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (rsp_valid === 1'b1) got <= rsp_rdata;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) bad_count++;
  endtask
  task automatic issue(input nvhc_op_e op, input logic [17:0] a,
                       input logic [15:0] d, input logic [1:0] ln,
                       input logic hw);
    int n;
    wait_ready(n);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_lanes = ln;
    req_valid = !hw;
    req_hw_store = hw;
    @(negedge clk);
    req_valid = 1'b0;
    req_hw_store = 1'b0;
    @(negedge clk);
    wait_ready(n);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    int n;
    wait_ready(n);
    check(16'(n >= LK), 16'h0001);
    $display("test powerup done");
  endtask
  task automatic t_lanes();
    issue(NVHC_OP_WRITE, 18'h20, 16'h1234, 2'b11, 1'b0);
    issue(NVHC_OP_WRITE, 18'h20, 16'habcd, 2'b01, 1'b0);
    issue(NVHC_OP_READ, 18'h20, 16'h0000, 2'b11, 1'b0);
    check(got, 16'h12cd);
    issue(NVHC_OP_READ, 18'h20, 16'h0000, 2'b10, 1'b0);
    check({8'h00, got[15:8]}, 16'h0012);
    issue(NVHC_OP_READ, 18'h20, 16'h0000, 2'b01, 1'b0);
    check({8'h00, got[7:0]}, 16'h00cd);
    $display("test lanes done");
  endtask
  task automatic t_soft();
    issue(NVHC_OP_WRITE, 18'h21, 16'h5a5a, 2'b11, 1'b0);
    issue(NVHC_OP_STORE, 18'h00, 16'h0000, 2'b11, 1'b0);
    check(16'(dev.stores), 16'h0001);
    issue(NVHC_OP_WRITE, 18'h21, 16'h0000, 2'b11, 1'b0);
    issue(NVHC_OP_RECALL, 18'h00, 16'h0000, 2'b11, 1'b0);
    check(16'(dev.cmds), 16'h0002);
    issue(NVHC_OP_READ, 18'h21, 16'h0000, 2'b11, 1'b0);
    check(got, 16'h5a5a);
    $display("test soft done");
  endtask
  task automatic t_hw();
    issue(NVHC_OP_READ, 18'h00, 16'h0000, 2'b11, 1'b1);
    check(16'(dev.stores), 16'h0001);
    issue(NVHC_OP_WRITE, 18'h22, 16'h0f0f, 2'b11, 1'b0);
    issue(NVHC_OP_READ, 18'h00, 16'h0000, 2'b11, 1'b1);
    check(16'(dev.stores), 16'h0002);
    check({15'h0000, sb_out}, 16'h0000);
    issue(NVHC_OP_READ, 18'h22, 16'h0000, 2'b11, 1'b0);
    check(got, 16'h0f0f);
    $display("test hw store done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_powerup();
    t_lanes();
    t_soft();
    t_hw();
    stop_test();
  end
  initial begin
    #1000000;
    bad_count++;
    stop_test();
  end
endmodule
